/* File: verilog/slot_seq_pkg.sv */
// constants and types shared by the time slot sequencer
package slot_seq_pkg;

	// phase train timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int PHASE_NS = 145;
	localparam int PHASE_CYCLES_RAW = PHASE_NS / CLK_PERIOD_NS;
	localparam int PHASE_CYCLES = (PHASE_CYCLES_RAW < 1) ? 1 : PHASE_CYCLES_RAW;
	localparam logic [4:0] PHASE_TIMER_LAST = 5'(PHASE_CYCLES - 1);
	localparam logic [4:0] PHASE_TIMER_RST = 5'h00;

	// phase numbers of the nine-phase train
	localparam logic [3:0] PH_1 = 4'h1;
	localparam logic [3:0] PH_2 = 4'h2;
	localparam logic [3:0] PH_3 = 4'h3;
	localparam logic [3:0] PH_6 = 4'h6;
	localparam logic [3:0] PH_7 = 4'h7;
	localparam logic [3:0] PH_9 = 4'h9;
	localparam logic [3:0] PHASE_RST = 4'h1;

	// slot counters
	localparam logic [4:0] A_CNT_RST = 5'h00;
	localparam logic [4:0] A_CNT_ALL_ONES = 5'h1f;
	localparam logic [5:0] B_CNT_RST = 6'h00;
	localparam logic [5:0] B_CNT_EXTRA = 6'h20;
	localparam logic [5:0] B_CNT_WRAP = 6'h21;
	localparam logic [5:0] TALK_FIRST = 6'h02;
	localparam logic [5:0] TALK_LAST = 6'h1f;
	localparam logic [5:0] SLOT_DATA_A1 = 6'h01;

	// store word map
	localparam logic [6:0] MSG_WORD = 7'h00;
	localparam logic [6:0] A_BASE = 7'h00;
	localparam logic [6:0] B_BASE = 7'h20;
	localparam logic [6:0] SCAN_BASE = 7'h40;
	localparam logic [6:0] SPARE_WORD = 7'h68;
	localparam logic [6:0] LAMP_BASE = 7'h70;
	localparam int STORE_ROWS = 16;
	localparam int STORE_COLS = 8;
	localparam int WORD_W = 32;
	localparam logic [31:0] WORD_RST = 32'h0000_0000;

	typedef enum logic [1:0] {
		RELOC_IDLE = 2'b00,
		RELOC_FETCH = 2'b01,
		RELOC_PLACE = 2'b11
	} reloc_state_t;

endpackage

/* File: verilog/one_hot_decode.sv */
// one-hot select decoder for store rows and columns
`timescale 1ns/100ps
module one_hot_decode #(
	parameter int IDX_W = 3,
	parameter int SEL_N = 8
) (
	input wire logic en,
	input wire logic [IDX_W-1:0] idx,
	output logic [SEL_N-1:0] sel
);
	always_comb
	begin
		sel = '0;
		for (int i = 0; i < SEL_N; i++)
		begin
			if (en && (int'(idx) == i))
				sel[i] = 1'b1;
		end
	end
endmodule

/* File: verilog/time_slot_sequencer.sv */
// time slot sequencing and local store control for one control half
// Function
// - A and B counters step alternately on phase three, chosen by one toggle stage.
// - Sixty-five slots per sequence: five-stage A gives 32, six-stage B gives 33.
// - A counter runs 0 to 31 and overflows naturally to zero.
// - B counter passes 31 into 32, resets at once when it would reach 100001.
// - All A counters and all B counters across halves stay in lockstep.
// - The controlling half pulses A sync once, as its A counter steps to all ones.
// - The controlling half pulses B sync whenever its B counter hits 100001.
// - First half sources sync normally; maintenance transfer moves it to second half lines.
// - Each slot spans nine phases of about 145 ns.
// - Store gates active low phase seven through next phase six identify A, B slots.
// - Connect gates active low phase three through phase two identify the same slots.
// - Store control P7 to P6, store cycle P1 to P6, connection control P3 to P2.
// - Phase-seven gate flip-flop gets a corrective reset on alternate phase nines.
// - Phase-seven flip-flop follows the phase-three flip-flop state at phase seven.
// - The corrective reset is harmless when aligned and realigns after a sync slip.
// - Translator gates A and B counts alternately and reads the word to output register.
// - Sixteen one-hot rows and eight one-hot columns, at most one of each asserted.
// - Lamp counter addresses only when enabled in slot A1; scan only with scan signal.
// - Incoming bits shift into output register LSB, written back and read per bit.
// - Both halves receive each message; the undesignated half discards it.
// - The designated half relocates a loaded message into the named talking slot word.
// - Slots 2 to 31 are talking; 0, 1 and B32 are data slots.
`timescale 1ns/100ps
module time_slot_sequencer (
	input wire logic CLK_SYS,
	input wire logic SYS_RST,
	input wire logic CLK_EN,
	input wire logic HALF_ID,
	input wire logic TRANSFER,
	input wire logic A_SYNC_IN_1,
	input wire logic B_SYNC_IN_1,
	input wire logic A_SYNC_IN_2,
	input wire logic B_SYNC_IN_2,
	output logic A_SYNC_PULSE_1,
	output logic B_SYNC_PULSE_1,
	output logic A_SYNC_PULSE_2,
	output logic B_SYNC_PULSE_2,
	output logic [3:0] PHASE,
	output logic [4:0] A_SLOT_COUNT,
	output logic [5:0] B_SLOT_COUNT,
	output logic A_STORE_GATE_N,
	output logic B_STORE_GATE_N,
	output logic A_CONNECT_GATE_N,
	output logic B_CONNECT_GATE_N,
	output logic TALKING_SLOT,
	output logic [15:0] STORE_ROW,
	output logic [7:0] STORE_COL,
	output logic STORE_READ,
	output logic STORE_WRITE,
	input wire logic [31:0] STORE_RD_DATA,
	output logic [31:0] OUT_WORD,
	input wire logic LAMP_COUNTER_ENABLE,
	input wire logic [3:0] LAMP_WORD,
	input wire logic SCAN_SLOT_SIGNAL,
	input wire logic [5:0] SCAN_WORD,
	input wire logic MSG_BIT,
	input wire logic MSG_BIT_VALID,
	input wire logic MSG_DONE,
	input wire logic MSG_FOR_HALF,
	input wire logic MSG_BLOCK_B,
	input wire logic [4:0] MSG_SLOT,
	output logic RELOCATE_BUSY
);
	// timing group
	logic [4:0] timer_q, timer_d;
	logic [3:0] phase_q, phase_d;
	logic gc3_q, gc3_d;
	logic gc7_q, gc7_d;
	logic p9_alt_q, p9_alt_d;
	logic [4:0] a_q, a_d;
	logic [5:0] b_q, b_d;
	logic a_sync_q, a_sync_d;
	logic b_sync_q, b_sync_d;
	logic step;
	logic source;
	logic sync_a_in;
	logic sync_b_in;
	logic [5:0] b_inc;

	// store group
	logic [31:0] out_q, out_d;
	logic [31:0] hold_q, hold_d;
	logic [15:0] row_q, row_d;
	logic [7:0] col_q, col_d;
	logic rd_q, rd_d;
	logic wr_q, wr_d;
	logic en_q, en_d;
	logic pend_q, pend_d;
	logic [6:0] target_q, target_d;
	slot_seq_pkg::reloc_state_t reloc_q, reloc_d;

	// slot decode
	logic blk_b;
	logic [5:0] cnt;
	logic talking;
	logic slot_a1;
	logic slot_b32;
	logic [6:0] addr;
	logic addr_en;
	logic [15:0] row_dec;
	logic [7:0] col_dec;

	// first half sources sync unless maintenance transfer hands it to the second
	assign source = (HALF_ID == TRANSFER);
	assign sync_a_in = TRANSFER ? A_SYNC_IN_2 : A_SYNC_IN_1;
	assign sync_b_in = TRANSFER ? B_SYNC_IN_2 : B_SYNC_IN_1;
	assign step = (timer_q == slot_seq_pkg::PHASE_TIMER_LAST);
	assign b_inc = b_q + 6'h01;

	always_comb
	begin
		timer_d = timer_q;
		phase_d = phase_q;
		gc3_d = gc3_q;
		gc7_d = gc7_q;
		p9_alt_d = p9_alt_q;
		a_d = a_q;
		b_d = b_q;
		a_sync_d = 1'b0;
		b_sync_d = 1'b0;
		if (step)
		begin
			timer_d = slot_seq_pkg::PHASE_TIMER_RST;
			// nine phases per slot, each PHASE_CYCLES clocks long
			if (phase_q == slot_seq_pkg::PH_9)
				phase_d = slot_seq_pkg::PH_1;
			else
				phase_d = phase_q + 4'h1;
			case (phase_d)
				slot_seq_pkg::PH_3:
				begin
					gc3_d = ~gc3_q;
					if (gc3_q)
					begin
						a_d = a_q + 5'h01;
						if (source && (a_d == slot_seq_pkg::A_CNT_ALL_ONES))
							a_sync_d = 1'b1;
					end
					else if (b_inc == slot_seq_pkg::B_CNT_WRAP)
					begin
						b_d = slot_seq_pkg::B_CNT_RST;
						b_sync_d = source;
					end
					else
						b_d = b_inc;
				end
				slot_seq_pkg::PH_7:
					gc7_d = gc3_q;
				slot_seq_pkg::PH_9:
				begin
					p9_alt_d = ~p9_alt_q;
					// only bites when a sync slip left gc7 set while gc3 is reset
					if (p9_alt_q && !gc3_q)
						gc7_d = 1'b0;
				end
				default:
				begin
				end
			endcase
		end
		else
			timer_d = timer_q + 5'h01;
		// followers jump to the master's state the cycle after its pulse
		if (!source && sync_a_in)
		begin
			a_d = slot_seq_pkg::A_CNT_ALL_ONES;
			gc3_d = 1'b0;
		end
		if (!source && sync_b_in)
		begin
			b_d = slot_seq_pkg::B_CNT_RST;
			gc3_d = 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			timer_q <= slot_seq_pkg::PHASE_TIMER_RST;
			phase_q <= slot_seq_pkg::PHASE_RST;
			gc3_q <= 1'b0;
			gc7_q <= 1'b0;
			p9_alt_q <= 1'b0;
			a_q <= slot_seq_pkg::A_CNT_RST;
			b_q <= slot_seq_pkg::B_CNT_RST;
			a_sync_q <= 1'b0;
			b_sync_q <= 1'b0;
		end
		else if (CLK_EN)
		begin
			timer_q <= timer_d;
			phase_q <= phase_d;
			gc3_q <= gc3_d;
			gc7_q <= gc7_d;
			p9_alt_q <= p9_alt_d;
			a_q <= a_d;
			b_q <= b_d;
			a_sync_q <= a_sync_d;
			b_sync_q <= b_sync_d;
		end
	end

	// the store window belongs to block B while gc7 is set
	assign blk_b = gc7_q;
	assign cnt = blk_b ? b_q : {1'b0, a_q};
	assign talking = (cnt >= slot_seq_pkg::TALK_FIRST) && (cnt <= slot_seq_pkg::TALK_LAST);
	assign slot_a1 = !blk_b && (cnt == slot_seq_pkg::SLOT_DATA_A1);
	assign slot_b32 = blk_b && (b_q == slot_seq_pkg::B_CNT_EXTRA);

	always_comb
	begin
		addr = slot_seq_pkg::MSG_WORD;
		addr_en = 1'b0;
		if (talking)
		begin
			addr_en = 1'b1;
			if (blk_b)
				addr = slot_seq_pkg::B_BASE | {2'b00, b_q[4:0]};
			else
				addr = slot_seq_pkg::A_BASE | {2'b00, a_q};
		end
		else if (slot_b32)
		begin
			addr_en = 1'b1;
			addr = slot_seq_pkg::MSG_WORD;
		end
		else if (slot_a1)
		begin
			addr_en = 1'b1;
			case (reloc_q)
				slot_seq_pkg::RELOC_FETCH:
					addr = slot_seq_pkg::MSG_WORD;
				slot_seq_pkg::RELOC_PLACE:
					addr = target_q;
				default:
					if (LAMP_COUNTER_ENABLE)
						addr = slot_seq_pkg::LAMP_BASE | {3'b000, LAMP_WORD};
					else
						addr = slot_seq_pkg::SPARE_WORD;
			endcase
		end
		else if (SCAN_SLOT_SIGNAL)
		begin
			addr_en = 1'b1;
			addr = slot_seq_pkg::SCAN_BASE | {1'b0, SCAN_WORD};
		end
	end

	one_hot_decode #(
		.IDX_W(4),
		.SEL_N(slot_seq_pkg::STORE_ROWS)
	) row_decode (
		.en(addr_en),
		.idx(addr[6:3]),
		.sel(row_dec)
	);

	one_hot_decode #(
		.IDX_W(3),
		.SEL_N(slot_seq_pkg::STORE_COLS)
	) col_decode (
		.en(addr_en),
		.idx(addr[2:0]),
		.sel(col_dec)
	);

	always_comb
	begin
		out_d = out_q;
		hold_d = hold_q;
		row_d = row_q;
		col_d = col_q;
		rd_d = 1'b0;
		wr_d = 1'b0;
		en_d = en_q;
		pend_d = pend_q;
		target_d = target_q;
		reloc_d = reloc_q;
		if (step)
		begin
			case (phase_d)
				slot_seq_pkg::PH_7:
				begin
					row_d = '0;
					col_d = '0;
					en_d = 1'b0;
				end
				slot_seq_pkg::PH_1:
				begin
					// select latched once per store cycle, at most one row and one column
					row_d = row_dec;
					col_d = col_dec;
					en_d = addr_en;
					rd_d = addr_en;
				end
				slot_seq_pkg::PH_2:
					if (en_q)
					begin
						if (slot_a1 && (reloc_q == slot_seq_pkg::RELOC_PLACE))
							out_d = hold_q;
						else
							out_d = STORE_RD_DATA;
						if (slot_a1 && (reloc_q == slot_seq_pkg::RELOC_FETCH))
							hold_d = STORE_RD_DATA;
					end
				slot_seq_pkg::PH_3:
					if (en_q && slot_b32 && MSG_BIT_VALID)
						out_d = {out_q[30:0], MSG_BIT};
				slot_seq_pkg::PH_6:
				begin
					// core read is destructive, so every read cycle writes back
					wr_d = en_q;
					if (slot_a1 && (reloc_q == slot_seq_pkg::RELOC_FETCH))
						reloc_d = slot_seq_pkg::RELOC_PLACE;
					else if (slot_a1 && (reloc_q == slot_seq_pkg::RELOC_PLACE))
					begin
						reloc_d = slot_seq_pkg::RELOC_IDLE;
						pend_d = 1'b0;
					end
					else if ((reloc_q == slot_seq_pkg::RELOC_IDLE) && pend_q)
						reloc_d = slot_seq_pkg::RELOC_FETCH;
				end
				default:
				begin
				end
			endcase
		end
		// the undesignated half simply drops the finished message
		if (MSG_DONE && (MSG_FOR_HALF == HALF_ID))
		begin
			pend_d = 1'b1;
			target_d = MSG_BLOCK_B ? (slot_seq_pkg::B_BASE | {2'b00, MSG_SLOT})
				: (slot_seq_pkg::A_BASE | {2'b00, MSG_SLOT});
		end
	end

	always_ff @(posedge CLK_SYS or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			out_q <= slot_seq_pkg::WORD_RST;
			hold_q <= slot_seq_pkg::WORD_RST;
			row_q <= '0;
			col_q <= '0;
			rd_q <= 1'b0;
			wr_q <= 1'b0;
			en_q <= 1'b0;
			pend_q <= 1'b0;
			target_q <= slot_seq_pkg::MSG_WORD;
			reloc_q <= slot_seq_pkg::RELOC_IDLE;
		end
		else if (CLK_EN)
		begin
			out_q <= out_d;
			hold_q <= hold_d;
			row_q <= row_d;
			col_q <= col_d;
			rd_q <= rd_d;
			wr_q <= wr_d;
			en_q <= en_d;
			pend_q <= pend_d;
			target_q <= target_d;
			reloc_q <= reloc_d;
		end
	end

	// first half drives the primary lines, second half the alternate ones
	assign A_SYNC_PULSE_1 = a_sync_q && !HALF_ID;
	assign B_SYNC_PULSE_1 = b_sync_q && !HALF_ID;
	assign A_SYNC_PULSE_2 = a_sync_q && HALF_ID;
	assign B_SYNC_PULSE_2 = b_sync_q && HALF_ID;
	assign PHASE = phase_q;
	assign A_SLOT_COUNT = a_q;
	assign B_SLOT_COUNT = b_q;
	assign A_STORE_GATE_N = gc7_q;
	assign B_STORE_GATE_N = ~gc7_q;
	assign A_CONNECT_GATE_N = gc3_q;
	assign B_CONNECT_GATE_N = ~gc3_q;
	assign TALKING_SLOT = talking;
	assign STORE_ROW = row_q;
	assign STORE_COL = col_q;
	assign STORE_READ = rd_q;
	assign STORE_WRITE = wr_q;
	assign OUT_WORD = out_q;
	assign RELOCATE_BUSY = pend_q;
endmodule

/* File: testbench/slot_seq_sva.sv */
// assertions on the time slot sequencer ports
`timescale 1ns/100ps
module slot_seq_sva (
	input wire logic CLK_SYS,
	input wire logic SYS_RST,
	input wire logic HALF_ID,
	input wire logic TRANSFER,
	input wire logic [3:0] PHASE,
	input wire logic [4:0] A_SLOT_COUNT,
	input wire logic [5:0] B_SLOT_COUNT,
	input wire logic A_STORE_GATE_N,
	input wire logic B_STORE_GATE_N,
	input wire logic A_CONNECT_GATE_N,
	input wire logic B_CONNECT_GATE_N,
	input wire logic [15:0] STORE_ROW,
	input wire logic [7:0] STORE_COL,
	input wire logic A_SYNC_PULSE_1,
	input wire logic B_SYNC_PULSE_1
);
	logic src;
	logic src0;
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (SYS_RST);
	// a follower may jump its counters, so stepping is only judged on the source
	assign src = (HALF_ID == TRANSFER);
	assign src0 = !HALF_ID && !TRANSFER;
	chk_phase_order: assert property (
		$changed(PHASE) |-> PHASE == (($past(PHASE) == 4'h9) ? 4'h1 : $past(PHASE) + 4'h1))
		else $error("phase out of order");
	chk_a_step: assert property (
		src && $changed(A_SLOT_COUNT) |-> PHASE == 4'h3 && A_SLOT_COUNT == $past(A_SLOT_COUNT) + 5'h01)
		else $error("bad a counter step");
	chk_b_step: assert property (
		src && $changed(B_SLOT_COUNT) |-> PHASE == 4'h3 &&
		B_SLOT_COUNT == (($past(B_SLOT_COUNT) == 6'h20) ? 6'h00 : $past(B_SLOT_COUNT) + 6'h01))
		else $error("bad b counter step");
	chk_gate_pair: assert property (
		A_STORE_GATE_N != B_STORE_GATE_N && A_CONNECT_GATE_N != B_CONNECT_GATE_N)
		else $error("gates not complementary");
	chk_gate_follow: assert property (
		$changed(PHASE) && PHASE == 4'h7 |-> A_STORE_GATE_N == A_CONNECT_GATE_N)
		else $error("store gate out of step");
	chk_one_word: assert property (
		$onehot0(STORE_ROW) && $countones(STORE_ROW) == $countones(STORE_COL))
		else $error("word select not one-hot");
	chk_a_sync: assert property (
		src0 && $changed(A_SLOT_COUNT) && A_SLOT_COUNT == 5'h1f |-> ##[0:1] A_SYNC_PULSE_1)
		else $error("a sync pulse missing");
	chk_b_sync: assert property (
		src0 && $changed(B_SLOT_COUNT) && B_SLOT_COUNT == 6'h00 |-> ##[0:1] B_SYNC_PULSE_1)
		else $error("b sync pulse missing");
	chk_sync_cause: assert property (
		!(A_SYNC_PULSE_1 && A_SLOT_COUNT != 5'h1f) && !(B_SYNC_PULSE_1 && B_SLOT_COUNT != 6'h00))
		else $error("sync pulse without cause");
endmodule

bind time_slot_sequencer slot_seq_sva slot_seq_sva_inst (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST),
	.HALF_ID(HALF_ID), .TRANSFER(TRANSFER), .PHASE(PHASE), .A_SLOT_COUNT(A_SLOT_COUNT),
	.B_SLOT_COUNT(B_SLOT_COUNT), .A_STORE_GATE_N(A_STORE_GATE_N), .B_STORE_GATE_N(B_STORE_GATE_N),
	.A_CONNECT_GATE_N(A_CONNECT_GATE_N), .B_CONNECT_GATE_N(B_CONNECT_GATE_N), .STORE_ROW(STORE_ROW),
	.STORE_COL(STORE_COL), .A_SYNC_PULSE_1(A_SYNC_PULSE_1), .B_SYNC_PULSE_1(B_SYNC_PULSE_1));

/* File: testbench/msg_source.sv */
// message source standing in for the remote control unit
`timescale 1ns/100ps
module msg_source (
	input wire logic clk,
	input wire logic go,
	input wire logic [1:0] bits,
	input wire logic [5:0] b_cnt,
	output logic m_bit,
	output logic m_vld,
	output logic fin
);
	logic was_b32;
	logic [1:0] n;
	initial
	begin
		{m_bit, m_vld, fin, was_b32, n} = 6'h00;
	end
	always @(negedge clk)
	begin
		if (go && n < 2'h2)
		begin
			// one bit per b32 slot, msb first, held the whole slot
			m_vld <= 1'b1;
			m_bit <= bits[2'h1 - n];
			n <= n + 2'((was_b32 && b_cnt != 6'h20) ? 1 : 0);
		end
		else
		begin
			// an idle line carries no stale bit
			m_vld <= 1'b0;
			m_bit <= ~m_bit;
		end
		was_b32 <= (b_cnt == 6'h20);
		fin <= (n == 2'h2);
	end
endmodule

/* File: testbench/tb.sv */
// self-checking bench for the time slot sequencer
`timescale 1ns/100ps
module tb;
	logic clk, rst, half, xfer, ai1, bi1, ai2, bi2, lamp_en, scan, done, for_half, blk_b, go, ce;
	logic [14:0] frz;
	logic ao1, bo1, ao2, bo2, a_sgn, b_sgn, a_cgn, b_cgn, tlk, st_rd, st_wr, busy, m_bit, m_vld, fin;
	logic [3:0] ph, lw;
	logic [4:0] a_cnt, slot, a;
	logic [5:0] b_cnt, sw, b;
	logic [15:0] row;
	logic [7:0] col, e;
	logic [31:0] rd, ow, last_w;
	logic [31:0] mem [128];
	logic [6:0] last_a;
	logic [1:0] bits;
	int cyc = 0, bad_count = 0, cmp_count = 0, t;
	time_slot_sequencer time_slot_sequencer_inst (.CLK_SYS(clk), .SYS_RST(rst), .CLK_EN(ce), .HALF_ID(half),
		.TRANSFER(xfer), .A_SYNC_IN_1(ai1), .B_SYNC_IN_1(bi1), .A_SYNC_IN_2(ai2), .B_SYNC_IN_2(bi2),
		.A_SYNC_PULSE_1(ao1), .B_SYNC_PULSE_1(bo1), .A_SYNC_PULSE_2(ao2), .B_SYNC_PULSE_2(bo2), .PHASE(ph),
		.A_SLOT_COUNT(a_cnt), .B_SLOT_COUNT(b_cnt), .A_STORE_GATE_N(a_sgn), .B_STORE_GATE_N(b_sgn),
		.A_CONNECT_GATE_N(a_cgn), .B_CONNECT_GATE_N(b_cgn), .TALKING_SLOT(tlk), .STORE_ROW(row), .STORE_COL(col),
		.STORE_READ(st_rd), .STORE_WRITE(st_wr), .STORE_RD_DATA(rd), .OUT_WORD(ow), .LAMP_COUNTER_ENABLE(lamp_en),
		.LAMP_WORD(lw), .SCAN_SLOT_SIGNAL(scan), .SCAN_WORD(sw), .MSG_BIT(m_bit), .MSG_BIT_VALID(m_vld),
		.MSG_DONE(done), .MSG_FOR_HALF(for_half), .MSG_BLOCK_B(blk_b), .MSG_SLOT(slot), .RELOCATE_BUSY(busy));
	msg_source msg_source_inst (.clk(clk), .go(go), .bits(bits), .b_cnt(b_cnt), .m_bit(m_bit), .m_vld(m_vld),
		.fin(fin));
	function automatic logic [6:0] enc(logic [15:0] r, logic [7:0] c);
		enc = 7'h00;
		for (int i = 0; i < 16; i++)
			if (r[i]) enc = {i[3:0], enc[2:0]};
		for (int i = 0; i < 8; i++)
			if (c[i]) enc[2:0] = i[2:0];
	endfunction
	function automatic logic [7:0] exp_addr();
		logic [5:0] s;
		s = a_sgn ? b_cnt : {1'b0, a_cnt};
		if (s == 6'h20)
			return 8'h00;
		if (|s[4:1])
			return {2'b00, a_sgn, s[4:0]};
		if (!a_sgn && s[0])
			return lamp_en ? 8'h70 + lw : 8'h68;
		return scan ? 8'h40 + sw : 8'hff;
	endfunction
	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
		@(negedge clk);
	endtask
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// store model; a deselected store shows a toggling pattern, never the last word
	assign rd = (|row) ? mem[enc(row, col)] : {32{cyc[0]}};
	always @(posedge clk)
		if (st_wr)
		begin
			mem[enc(row, col)] <= ow;
			last_w <= ow;
			last_a <= enc(row, col);
		end
	// lamp and scan inputs move at phase five so they stand still over the p1 choice
	always @(negedge clk)
		if (ph == 4'h5)
			{lamp_en, scan, lw, sw} <= 12'($urandom);
	always @(negedge clk)
		if (st_rd && !(busy && a_cnt == 5'h01))
		begin
			e = exp_addr();
			check("addr", enc(row, col), e);
			check("talk", tlk, e < 8'h40 && |e[4:1]);
		end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 99000)
		begin
			bad_count++;
			give_verdict();
		end
	end
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial
	begin
		{rst, half, xfer, ai1, bi1, ai2, bi2, lamp_en, scan, done, for_half, blk_b, go} = 13'h1000;
		{lw, sw, slot, bits} = 17'h0_0000;
		ce = 1'b1;
		void'($urandom(32'h0000_a3dd));
		for (int i = 0; i < 128; i++)
			mem[i] = $urandom;
		bits = 2'($urandom);
		repeat (6) @(negedge clk);
		check("reset", {ph, a_cnt, b_cnt, a_sgn, b_sgn, a_cgn, b_cgn}, {4'h1, 11'h000, 4'b0101});
		rst = 1'b0;
		$display("reset test done");
		a = a_cnt;
		do @(negedge clk); while (a_cnt == a);
		t = cyc;
		b = b_cnt;
		do @(negedge clk); while (b_cnt == b);
		check("slot_len", cyc - t, 261);
		check("b_step", b_cnt, b + 6'h01);
		do @(negedge clk); while (a_cnt == a + 5'h01);
		check("a_gap", cyc - t, 522);
		check("a_step", a_cnt, a + 5'h02);
		$display("timing test done");
		go = 1'b1;
		for (int k = 0; k < 2; k++)
		begin
			do @(negedge clk); while (!(b_cnt == 6'h20 && ph == 4'h4 && !b_sgn));
			check("msg_bits", k ? ow[1:0] : ow[0], k ? bits : bits[1]);
			do @(negedge clk); while (b_cnt == 6'h20);
		end
		do @(negedge clk); while (!fin);
		$display("message test done");
		for_half = 1'b1;
		pulse(done);
		check("discard", busy, 1'b0);
		{blk_b, slot} = {1'($urandom), 5'h02 + 5'($urandom % 30)};
		for_half = 1'b0;
		done = 1'b1;
		@(negedge clk);
		done = 1'b0;
		check("busy", busy, 1'b1);
		do @(negedge clk); while (busy);
		@(negedge clk);
		check("reloc_word", last_a, {blk_b, slot});
		check("reloc_data", last_w[1:0], bits);
		$display("relocation test done");
		do @(negedge clk); while (ph != 4'h4);
		xfer = 1'b1;
		b = b_cnt;
		pulse(ai2);
		check("a_sync", {a_cnt, a_cgn}, {5'h1f, 1'b0});
		pulse(bi1);
		check("b_ignored", b_cnt, b);
		pulse(bi2);
		check("b_sync", {b_cnt, b_cgn}, {6'h00, 1'b0});
		half = 1'b1;
		a = a_cnt;
		pulse(ai2);
		check("src_ignores", a_cnt, a);
		do @(negedge clk); while (!ao2);
		check("a_sync_alt", {a_cnt, ao1, bo2}, {5'h1f, 2'b00});
		$display("sync test done");
		// a low enable must freeze the phase train and both counters
		ce = 1'b0;
		@(negedge clk);
		frz = {ph, a_cnt, b_cnt};
		repeat (40) @(negedge clk);
		check("freeze", {ph, a_cnt, b_cnt}, frz);
		ce = 1'b1;
		$display("enable test done");
		give_verdict();
	end
endmodule
